/* File: design/bcmc_params.svh */
// Offsets, field positions, codes, reset values and timing counts of the mode control block
`ifndef BCMC_PARAMS_SVH
`define BCMC_PARAMS_SVH

// Register byte offsets on the AHB-Lite slave
`define BCMC_OFF_CTRL      8'h00
`define BCMC_OFF_STATUS    8'h04
`define BCMC_OFF_LOCAL_IN  8'h08
`define BCMC_OFF_DEBUG_OUT 8'h0c
`define BCMC_OFF_XO_BASE   8'h10
`define BCMC_OFF_XI_BASE   8'h20

// Control register fields
`define BCMC_CTRL_RUN_BIT  0
`define BCMC_CTRL_DBG_BIT  1
`define BCMC_CTRL_ENC_LSB  2
`define BCMC_CTRL_MRES_BIT 4
`define BCMC_CTRL_WIDTH    5
`define BCMC_CTRL_RST      5'h00

// Encoder choice codes
`define BCMC_ENC_NONE 2'h0
`define BCMC_ENC_DIFF 2'h1
`define BCMC_ENC_SE   2'h2
`define BCMC_ENC_SSI  2'h3

// Three-position selector switch codes
`define BCMC_SW_STOP 2'h0
`define BCMC_SW_RUN  2'h1
`define BCMC_SW_MRES 2'h2

// Local point counts and exchange size
`define BCMC_NUM_IN     15
`define BCMC_NUM_OUT    8
`define BCMC_XCHG_BYTES 16

// Program evaluation time and clock period, both in ns
`define BCMC_EXEC_NS 1000
`define BCMC_CLK_NS  4
`define BCMC_EXEC_CYC (`BCMC_EXEC_NS / `BCMC_CLK_NS)

`endif

/* File: design/bcmc_pkg.sv */
// Types shared by the mode control block
package bcmc_pkg;

   // Top-level operating state
   typedef enum logic [1:0] {
      BCMC_LOAD,
      BCMC_STOP,
      BCMC_RUN
   } bcmc_state_e;

   // Control register as stored
   typedef struct packed {
      logic mres;
      logic [1:0] enc_sel;
      logic debug;
      logic run_cmd;
   } bcmc_ctrl_s;

   // Captured AHB address phase
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
   } bcmc_aphase_s;

endpackage

/* File: design/bcmc_top.sv */
// Operating mode control of the Boolean coprocessor: load, run/stop, debug and host exchange
`include "bcmc_params.svh"

// Function
// [R1] Fifteen local inputs, eight local outputs
// [R2] One encoder type selected at a time
// [R3] Diff or serial encoder frees inputs 8-11
// [R4] No encoder frees inputs 12-14
// [R5] Load card image at power-up, memory reset
// [R6] Sixteen bytes exchanged each way with master
// [R7] Master cannot reach local I/O normally; the status register shows the local outputs at all times
// [R8] Master run command honoured only at RUN
// [R9] Stand-alone runs when switch at RUN
// [R10] Debug passes local I/O to master
// [R11] Fixed one microsecond program evaluation time
// [R12] Selector switch gates program execution
// [R13] Stop holds outputs off, suspends evaluation
module bcmc_top
   import bcmc_pkg::*;
#(
   parameter int PROG_AW = 16,                  // Program image address width
   parameter int EXEC_CYC = `BCMC_EXEC_CYC      // Evaluation period in clocks
) (
   input wire logic hclk,                       // Bus clock, 250 MHz
   input wire logic hresetn,                    // Async reset, active low
   input wire logic hsel,                       // Slave select
   input wire logic [31:0] haddr,               // Byte address
   input wire logic [1:0] htrans,               // Transfer type
   input wire logic hwrite,                     // Write when high
   input wire logic [2:0] hsize,                // Transfer size
   input wire logic [31:0] hwdata,              // Write data
   input wire logic hready,                     // Bus ready
   output logic [31:0] hrdata,                  // Read data
   output logic hreadyout,                      // Slave ready
   output logic hresp,                          // Always OKAY
   input wire logic [1:0] mode_sw,              // Selector switch position
   input wire logic standalone,                 // High when no master present
   input wire logic [7:0] din,                  // Plain 24 V inputs 0-7
   input wire logic [3:0] enc_se,               // Single-ended encoder lines
   input wire logic [2:0] enc_diff,             // Differential input pairs
   output logic [`BCMC_NUM_OUT-1:0] dout,       // Local outputs
   output logic [1:0] enc_sel_o,                // Encoder type in use
   output logic card_req,                       // Ready for a card word
   input wire logic card_valid,                 // Card word present
   input wire logic [31:0] card_data,           // Card word
   input wire logic card_last,                  // Last word of image
   output logic cfg_we,                         // Image word write strobe
   output logic [PROG_AW-1:0] cfg_addr,         // Image word address
   output logic [31:0] cfg_data,                // Image word
   output logic cfg_done,                       // Image loaded
   output logic [`BCMC_NUM_IN-1:0] ulp_in,      // Inputs given to user program
   input wire logic [`BCMC_NUM_OUT-1:0] ulp_out, // Results of user program
   output logic ulp_enable,                     // User program evaluating
   output logic [8*`BCMC_XCHG_BYTES-1:0] xo_data, // Master to program bytes
   input wire logic [8*`BCMC_XCHG_BYTES-1:0] xi_data, // Program to master bytes
   output logic run_o                           // Module in RUN
);

   localparam int XWORDS = `BCMC_XCHG_BYTES / 4; // Exchange words each way

   // Elaboration checks on parameters; the counter is 8 bits wide
   if (EXEC_CYC < 2 || EXEC_CYC > 256) begin : g_bad_exec
      $error("EXEC_CYC must lie in 2..256");
   end
   if (PROG_AW < 1 || PROG_AW > 24) begin : g_bad_aw
      $error("PROG_AW must lie in 1..24");
   end

   // Bus side state
   bcmc_aphase_s ap_r;                          // Pending data phase
   logic rd_done_r;                             // Read data already loaded
   logic [31:0] hrdata_r;                       // Registered read data
   bcmc_ctrl_s ctrl_r;                          // Control register
   logic [`BCMC_NUM_OUT-1:0] dbg_out_r;         // Debug output values
   logic [31:0] xo_r [XWORDS];                  // Master to program words

   // Mode state
   bcmc_state_e state_r;                        // Operating state
   bcmc_state_e state_nxt;                      // Next operating state
   logic [PROG_AW-1:0] ld_addr_r;               // Image word counter
   logic loaded_r;                              // Image fully in place
   logic sw_mres_r;                             // Switch was at MRES
   logic cfg_we_r;                              // Image write strobe
   logic [31:0] cfg_data_r;                     // Image word
   logic [PROG_AW-1:0] cfg_addr_r;              // Image address

   // Evaluation state
   logic [7:0] exec_cnt_r;                      // Cycle within evaluation period
   logic primed_r;                              // One input sample taken
   logic [`BCMC_NUM_IN-1:0] ulp_in_r;           // Sampled inputs for program
   logic [`BCMC_NUM_OUT-1:0] dout_r;            // Driven local outputs

   // Address phase decode
   wire ap_take = hsel & hready & htrans[1];
   wire [7:0] ap_addr = haddr[7:0];
   // Data phase decode, writes complete with no wait state
   wire wr_en = ap_r.wr;
   wire rd_busy = ap_r.rd & ~rd_done_r;
   wire [5:0] wr_idx = ap_r.addr[7:2];
   wire wr_ctrl = wr_en && (ap_r.addr == `BCMC_OFF_CTRL);
   wire wr_dbg = wr_en && (ap_r.addr == `BCMC_OFF_DEBUG_OUT);

   // Local input assembly with encoder-dependent reuse of lines
   wire [1:0] enc = ctrl_r.enc_sel;             // Exactly one type held at once
   wire se_free = (enc == `BCMC_ENC_DIFF) || (enc == `BCMC_ENC_SSI); // [R3]
   wire diff_free = (enc == `BCMC_ENC_NONE);    // [R4]
   wire [`BCMC_NUM_IN-1:0] local_in = {
      diff_free ? enc_diff : 3'h0,              // Inputs 12-14 [R4]
      se_free ? enc_se : 4'h0,                  // Inputs 8-11 [R3]
      din                                       // Inputs 0-7 [R1]
   };

   // Run gating from switch, master and stand-alone strap
   wire sw_run = (mode_sw == `BCMC_SW_RUN);     // [R12]
   wire sw_mres = (mode_sw == `BCMC_SW_MRES);
   wire mres_req = (wr_ctrl && hwdata[`BCMC_CTRL_MRES_BIT]) || (sw_mres && !sw_mres_r);
   wire run_ok = loaded_r && sw_run && (standalone || ctrl_r.run_cmd); // [R8] [R9] [R12]
   wire in_run = (state_r == BCMC_RUN);
   wire dbg_act = ctrl_r.debug && !standalone;  // Debug needs a master
   wire eval_on = in_run && !dbg_act;           // Program evaluates only here [R13]
   wire exec_wrap = (exec_cnt_r == 8'(EXEC_CYC - 1));
   wire card_take = (state_r == BCMC_LOAD) && card_valid;

   // Read mux, local inputs visible to the master only in debug, local outputs always in status
   logic [31:0] rd_mux;
   wire [3:0] st_code = {2'h0, state_r};
   wire [31:0] status_w = {16'h0, dout_r, 1'b0, dbg_act, standalone, loaded_r, mode_sw,
                           st_code[1:0]};
   wire [31:0] local_w = dbg_act ? {17'h0, local_in} : 32'h0; // [R7] [R10]
   wire [31:0] dbgo_w = {24'h0, dbg_out_r};
   wire [31:0] ctrl_w = {27'h0, ctrl_r};
   wire rd_xo = (ap_r.addr >= `BCMC_OFF_XO_BASE) && (ap_r.addr < `BCMC_OFF_XI_BASE);
   wire rd_xi = (ap_r.addr >= `BCMC_OFF_XI_BASE) &&
                (ap_r.addr < (`BCMC_OFF_XI_BASE + 8'(`BCMC_XCHG_BYTES)));
   wire [1:0] xw = ap_r.addr[3:2];              // Word within exchange block

   // Combinational read select, unmapped reads return zero
   always_comb begin
      rd_mux = 32'h0;
      if (ap_r.addr == `BCMC_OFF_CTRL) begin
         rd_mux = ctrl_w;
      end else if (ap_r.addr == `BCMC_OFF_STATUS) begin
         rd_mux = status_w;
      end else if (ap_r.addr == `BCMC_OFF_LOCAL_IN) begin
         rd_mux = local_w;
      end else if (ap_r.addr == `BCMC_OFF_DEBUG_OUT) begin
         rd_mux = dbgo_w;
      end else if (rd_xo) begin
         rd_mux = xo_r[xw];                     // [R6]
      end else if (rd_xi) begin
         rd_mux = xi_data[32*xw +: 32];         // [R6]
      end
   end

   // Address phase capture; reads hold hreadyout low for one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r <= '0;
         rd_done_r <= 1'b0;
      end else if (hready) begin
         ap_r <= ap_take ? {hwrite, ~hwrite, ap_addr} : '0;
         rd_done_r <= 1'b0;
      end else if (rd_busy) begin
         rd_done_r <= 1'b1;
      end
   end

   // Read data register loaded in the wait cycle, after any prior write landed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0;
      end else if (rd_busy) begin
         hrdata_r <= rd_mux;
      end
   end

   // Control register; mres is a pulse and never stored as one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `BCMC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= {1'b0, hwdata[`BCMC_CTRL_ENC_LSB +: 2], hwdata[`BCMC_CTRL_DBG_BIT],
                    hwdata[`BCMC_CTRL_RUN_BIT]}; // [R2] [R8]
      end
   end

   // Debug output values, used only while debug is active
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dbg_out_r <= '0;
      end else if (wr_dbg) begin
         dbg_out_r <= hwdata[`BCMC_NUM_OUT-1:0]; // [R10]
      end
   end

   // Master to program exchange words, one per aligned offset
   genvar gi;
   generate
      for (gi = 0; gi < XWORDS; gi++) begin : g_xo
         wire hit = wr_en && (wr_idx == 6'((`BCMC_OFF_XO_BASE >> 2) + gi));
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               xo_r[gi] <= 32'h0;
            end else if (hit) begin
               xo_r[gi] <= hwdata;              // [R6]
            end
         end
         assign xo_data[32*gi +: 32] = xo_r[gi];
      end
   endgenerate

   // Next state: memory reset always wins, then load, then run gating
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BCMC_LOAD: begin
            if (card_take && card_last) begin
               state_nxt = BCMC_STOP;          // [R5]
            end
         end
         BCMC_STOP: begin
            if (run_ok) begin
               state_nxt = BCMC_RUN;           // [R8] [R9]
            end
         end
         BCMC_RUN: begin
            if (!run_ok) begin
               state_nxt = BCMC_STOP;          // [R12]
            end
         end
         default: begin
            state_nxt = BCMC_LOAD;
         end
      endcase
      if (mres_req) begin
         state_nxt = BCMC_LOAD;                 // [R5]
      end
   end

   // State, switch edge history and image load progress
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= BCMC_LOAD;                  // Power-up starts a load [R5]
         sw_mres_r <= 1'b0;
         loaded_r <= 1'b0;
         ld_addr_r <= '0;
      end else begin
         state_r <= state_nxt;
         sw_mres_r <= sw_mres;
         if (mres_req) begin
            loaded_r <= 1'b0;
            ld_addr_r <= '0;
         end else if (card_take) begin
            loaded_r <= card_last;
            ld_addr_r <= ld_addr_r + PROG_AW'(1); // Wraps on an oversize image
         end
      end
   end

   // Image words are forwarded to the programmable fabric as they arrive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_we_r <= 1'b0;
         cfg_addr_r <= '0;
         cfg_data_r <= 32'h0;
      end else begin
         cfg_we_r <= card_take && !mres_req;    // [R5]
         if (card_take) begin
            cfg_addr_r <= ld_addr_r;
            cfg_data_r <= card_data;
         end
      end
   end

   // Evaluation period counter, parked at its end so RUN starts with a sample
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exec_cnt_r <= 8'(EXEC_CYC - 1);
         primed_r <= 1'b0;
      end else if (!eval_on) begin
         exec_cnt_r <= 8'(EXEC_CYC - 1);        // Suspended in STOP [R13]
         primed_r <= 1'b0;
      end else if (exec_wrap) begin
         exec_cnt_r <= 8'h0;
         primed_r <= 1'b1;
      end else begin
         exec_cnt_r <= exec_cnt_r + 8'h1;
      end
   end

   // Inputs sampled and results taken once per fixed period, so the
   // program always sees exactly one period between sample and update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ulp_in_r <= '0;
      end else if (!in_run) begin
         ulp_in_r <= '0;                        // [R13]
      end else if (eval_on && exec_wrap) begin
         ulp_in_r <= local_in;                  // [R11]
      end
   end

   // Local outputs: off outside RUN, master values in debug, program results else
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout_r <= '0;
      end else if (!in_run) begin
         dout_r <= '0;                          // [R13]
      end else if (dbg_act) begin
         dout_r <= dbg_out_r;                   // [R10]
      end else if (exec_wrap && primed_r) begin
         dout_r <= ulp_out;                     // [R11] [R7]
      end
   end

   // Output assignments
   assign hrdata = hrdata_r;
   assign hreadyout = ~rd_busy;
   assign hresp = 1'b0;
   assign dout = dout_r;
   assign enc_sel_o = ctrl_r.enc_sel;           // [R2]
   assign card_req = (state_r == BCMC_LOAD);
   assign cfg_we = cfg_we_r;
   assign cfg_addr = cfg_addr_r;
   assign cfg_data = cfg_data_r;
   assign cfg_done = loaded_r;
   assign ulp_in = ulp_in_r;
   assign ulp_enable = eval_on;
   assign run_o = in_run;

endmodule

/* File: verification/bcmc_card_model.sv */
// Program card and user program stand-in on the far side of the block
module bcmc_card_model #(
   parameter int IMG_WORDS = 5 // Words in the stored image
) (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, active low
   input wire logic slow, // Offer a word only every other cycle
   input wire logic card_req, // Device wants a word
   output logic card_valid, // Word on offer
   output logic [31:0] card_data, // Image word
   output logic card_last, // Last word of image
   input wire logic [14:0] ulp_in, // Inputs of the program
   output logic [7:0] ulp_out // Results of the program
);
   timeunit 1ns;
   timeprecision 1ps;
   int idx; // Next word number
   logic gap; // Pacing toggle for slow mode
   // Fixed mix of inputs so the bench can predict results
   assign ulp_out = ulp_in[7:0] ^ {1'b0, ulp_in[14:8]};
   // Idle card data toggles so a stale word is never mistaken for a fresh one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx <= 0;
         gap <= 1'b0;
         card_valid <= 1'b0;
         card_last <= 1'b0;
         card_data <= 32'hffffffff;
      end else begin
         gap <= ~gap;
         if (card_valid && card_req) begin
            card_valid <= 1'b0;
            card_last <= 1'b0;
            card_data <= ~card_data;
            idx <= idx + 1;
         end else if (!card_req) begin // Image restarts at word 0
            idx <= 0;
            card_data <= ~card_data;
         end else if (!card_valid && (!slow || gap)) begin
            card_valid <= 1'b1;
            card_data <= 32'hc0de0000 + 32'(idx);
            card_last <= (idx == IMG_WORDS - 1);
         end
      end
   end
endmodule

/* File: verification/bcmc_properties.sv */
// Port-level assertions for the mode control block, bound to its top module
`include "bcmc_params.svh"
module bcmc_properties (
   input wire logic hclk, // Bus clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic [1:0] mode_sw, // Selector switch
   input wire logic [7:0] dout, // Local outputs
   input wire logic card_req, // Card word wanted
   input wire logic card_valid, // Card word present
   input wire logic cfg_we, // Image word strobe
   input wire logic cfg_done, // Image loaded
   input wire logic ulp_enable, // Program evaluating
   input wire logic run_o // In RUN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Address phases taken by the slave
   wire rd_take = hsel && hready && htrans[1] && !hwrite;
   wire wr_take = hsel && hready && htrans[1] && hwrite;
   wire sw_mres = (mode_sw == `BCMC_SW_MRES);
   chk_bus_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait");
   chk_write_nowait: assert property (wr_take |=> hreadyout)
      else $error("write data phase stalled");
   chk_switch_gate: assert property (mode_sw != `BCMC_SW_RUN |=> !run_o)
      else $error("running with switch off RUN");
   chk_run_cause: assert property ($rose(run_o) |->
      $past(cfg_done) && $past(mode_sw) == `BCMC_SW_RUN)
      else $error("RUN entered without image and switch");
   // A loaded block out of RUN clears its outputs on the next edge
   chk_stop_dout: assert property (!run_o && cfg_done |=> dout == 8'h00)
      else $error("outputs not cleared in stop");
   chk_eval_gate: assert property (ulp_enable |-> run_o)
      else $error("evaluation outside RUN");
   chk_card_take: assert property (card_req && card_valid |=> cfg_we)
      else $error("card word not written");
   chk_card_idle: assert property (!(card_req && card_valid) |=> !cfg_we)
      else $error("image strobe without card word");
   chk_load_flag: assert property (card_req != cfg_done)
      else $error("load request and done disagree");
   chk_mres_entry: assert property (sw_mres && !$past(sw_mres) |=> card_req && !cfg_done)
      else $error("switch memory reset did not reload");
   cover property ($rose(run_o));
   cover property ($fell(cfg_done));
   cover property (rd_take ##2 wr_take);
endmodule

bind bcmc_top bcmc_properties bcmc_properties_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .mode_sw(mode_sw), .dout(dout), .card_req(card_req), .card_valid(card_valid),
   .cfg_we(cfg_we), .cfg_done(cfg_done), .ulp_enable(ulp_enable), .run_o(run_o));

/* File: verification/testbench.sv */
// Self-checking bench: bus tasks, mode, evaluation, debug, exchange and reload
`include "bcmc_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EXEC = 4; // Short evaluation period keeps the run brief
   localparam int IMG = 5; // Image words on the card
   logic hclk, hresetn, hwrite, card_valid, card_last, cfg_we, cfg_done, card_req;
   logic hreadyout, hresp, standalone, slow, ulp_enable, run_o;
   logic [1:0] htrans, mode_sw, enc_sel_o;
   logic [31:0] haddr, hwdata, hrdata, card_data, rd, cfg_data;
   logic [15:0] cfg_addr;
   logic [7:0] din, dout, ulp_out;
   logic [3:0] enc_se;
   logic [2:0] enc_diff;
   logic [14:0] ulp_in, x;
   logic [127:0] xo_data, xi_data;
   int err_total = 0; // Mismatches
   int checks_done = 0; // Comparisons
   int we_cnt = 0; // Image words written
   int cyc = 0; // Cycle count for the hang limit
   bcmc_top #(.PROG_AW(16), .EXEC_CYC(EXEC)) bcmc_top_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .mode_sw(mode_sw), .standalone(standalone), .din(din), .enc_se(enc_se),
      .enc_diff(enc_diff), .dout(dout), .enc_sel_o(enc_sel_o), .card_req(card_req),
      .card_valid(card_valid), .card_data(card_data), .card_last(card_last), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_done(cfg_done), .ulp_in(ulp_in),
      .ulp_out(ulp_out),
      .ulp_enable(ulp_enable), .xo_data(xo_data), .xi_data(xi_data), .run_o(run_o));
   bcmc_card_model #(.IMG_WORDS(IMG)) bcmc_card_model_i (.hclk(hclk), .hresetn(hresetn),
      .slow(slow), .card_req(card_req), .card_valid(card_valid), .card_data(card_data),
      .card_last(card_last), .ulp_in(ulp_in), .ulp_out(ulp_out));
   always #2 hclk = ~hclk;
   // Image words seen leaving the block, taken at the falling edge where they are settled
   always @(negedge hclk) begin
      if (cfg_we === 1'b1) begin
         check("image address", 32'(we_cnt % IMG), {16'h0, cfg_addr});
         check("image word", 32'hc0de0000 + 32'(we_cnt % IMG), cfg_data);
         we_cnt++;
      end
   end
   // Hang limit, far above the few hundred cycles the tests need
   always @(posedge hclk) begin
      cyc++;
      if (cyc > 30000) begin
         err_total++;
         $display("MISMATCH run length expected %0d seen %0d", 30000, cyc);
         conclude();
      end
   end
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Address phase held until ready, then data phase held until ready
   task automatic ahb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wait_load();
      do @(posedge hclk); while (cfg_done !== 1'b1);
   endtask
   // Local inputs the program should see for an encoder choice
   function automatic logic [14:0] exp_in(input logic [1:0] e);
      exp_in = {(e == `BCMC_ENC_NONE) ? enc_diff : 3'h0,
         (e == `BCMC_ENC_DIFF || e == `BCMC_ENC_SSI) ? enc_se : 4'h0, din};
   endfunction
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {htrans, hwrite, haddr, hwdata, din, enc_se, enc_diff, standalone} = '0;
      mode_sw = `BCMC_SW_STOP;
      slow = 1'b1;
      xi_data = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
      tick(20);
      hresetn <= 1'b1;
      wait_load();
      check("image words", IMG, we_cnt);
      ahb_xfer(1'b1, `BCMC_OFF_STATUS, 32'hffffffff);
      ahb_xfer(1'b0, 8'h40, 32'h0);
      check("unmapped read", 32'h0, rd);
      mode_sw <= `BCMC_SW_RUN;
      din <= 8'ha5;
      enc_se <= 4'h9;
      enc_diff <= 3'h5;
      slow <= 1'b0;
      ahb_xfer(1'b0, `BCMC_OFF_STATUS, 32'h0);
      check("status without command", 32'h00000015, rd);
      for (int e = 0; e < 4; e++) begin
         ahb_xfer(1'b1, `BCMC_OFF_CTRL, {28'h0, 2'(e), 2'b01});
         tick(3 * EXEC + 4);
         x = exp_in(2'(e));
         check("encoder", 32'(e), {30'h0, enc_sel_o});
         check("run", 32'h1, {31'h0, run_o});
         check("program inputs", {17'h0, x}, {17'h0, ulp_in});
         check("outputs", {24'h0, x[7:0] ^ {1'b0, x[14:8]}}, {24'h0, dout});
         ahb_xfer(1'b0, `BCMC_OFF_LOCAL_IN, 32'h0);
         check("local in hidden", 32'h0, rd);
      end
      ahb_xfer(1'b1, `BCMC_OFF_CTRL, 32'h3);
      ahb_xfer(1'b1, `BCMC_OFF_DEBUG_OUT, 32'h3c);
      tick(2);
      check("debug outputs", 32'h3c, {24'h0, dout});
      check("debug eval off", 32'h0, {31'h0, ulp_enable});
      ahb_xfer(1'b0, `BCMC_OFF_LOCAL_IN, 32'h0);
      check("debug inputs", {17'h0, exp_in(`BCMC_ENC_NONE)}, rd);
      mode_sw <= `BCMC_SW_STOP;
      tick(3);
      check("stop", 32'h0, {31'h0, run_o});
      check("stop outputs", 32'h0, {24'h0, dout});
      check("stop inputs", 32'h0, {17'h0, ulp_in});
      // The written word lands at the edge ending the write, so look after the next read
      for (int i = 0; i < 4; i++) begin
         ahb_xfer(1'b1, `BCMC_OFF_XO_BASE + 8'(4 * i), {4{8'(17 * i + 3)}});
         ahb_xfer(1'b0, `BCMC_OFF_XO_BASE + 8'(4 * i), 32'h0);
         check("host out readback", {4{8'(17 * i + 3)}}, rd);
         check("host out word", {4{8'(17 * i + 3)}}, xo_data[32 * i +: 32]);
         ahb_xfer(1'b0, `BCMC_OFF_XI_BASE + 8'(4 * i), 32'h0);
         check("host in word", xi_data[32 * i +: 32], rd);
      end
      standalone <= 1'b1;
      mode_sw <= `BCMC_SW_RUN;
      ahb_xfer(1'b1, `BCMC_OFF_CTRL, 32'h0);
      tick(3);
      check("stand-alone run", 32'h1, {31'h0, run_o});
      ahb_xfer(1'b1, `BCMC_OFF_CTRL, 32'h10);
      tick(2);
      check("reload request", 32'h1, {31'h0, card_req});
      wait_load();
      check("reload words", 2 * IMG, we_cnt);
      tick(3);
      check("run after reload", 32'h1, {31'h0, run_o});
      mode_sw <= `BCMC_SW_MRES;
      slow <= 1'b1;
      tick(2);
      check("switch reload", 32'h0, {31'h0, cfg_done});
      wait_load();
      check("switch reload words", 3 * IMG, we_cnt);
      conclude();
   end
endmodule
